// *** rtl/spp_pkg.sv ***
// Package for the serial peripheral port: register map, field positions, resets.
// Assumes a byte-wide peripheral on a 16-bit bus with one system clock.
`default_nettype none
package spp_pkg;
    localparam logic [15:0] ADDR_CONFIG = 16'h7040;
    localparam logic [15:0] ADDR_OPCTL = 16'h7041;
    localparam logic [15:0] ADDR_STATUS = 16'h7042;
    localparam logic [15:0] ADDR_BRATE = 16'h7044;
    localparam logic [15:0] ADDR_EMU = 16'h7046;
    localparam logic [15:0] ADDR_RXBUF = 16'h7047;
    localparam logic [15:0] ADDR_SHIFT = 16'h7049;
    localparam logic [15:0] ADDR_PC1 = 16'h704D;
    localparam logic [15:0] ADDR_PC2 = 16'h704E;
    localparam logic [15:0] ADDR_PRI = 16'h704F;
    // config_control fields
    localparam int CFG_SWRST = 7;
    localparam int CFG_POL = 6;
    // operation_control fields
    localparam int CTL_OVR_IE = 4;
    localparam int CTL_PHASE = 3;
    localparam int CTL_MASTER = 2;
    localparam int CTL_TALK = 1;
    localparam int CTL_CC_IE = 0;
    // port_status fields
    localparam int STS_OVR = 7;
    localparam int STS_CC = 6;
    // pin_control_one: strobe function select
    localparam int PC1_STB_FN = 5;
    localparam int PRI_LEVEL = 6;
    localparam int PRI_SUSP = 5;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNDEF_READ = 8'h00;
    localparam logic [6:0] BRATE_MIN = 7'h03;
    localparam logic [6:0] BRATE_SLOW_DIV = 7'h03;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
endpackage : spp_pkg
`default_nettype wire

// *** rtl/spp_fifo_if.sv ***
// Interface carrying one valid/ready stream of received characters.
// Assumes both ends share clk_sys.
`default_nettype none
interface spp_fifo_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : spp_fifo_if
`default_nettype wire

// *** rtl/spp_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and asynchronous active-low reset.
`default_nettype none
module spp_fifo
    import spp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flush,
    spp_fifo_if.sink in_s,
    spp_fifo_if.source out_s
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } spp_fifo_state_t;
    spp_fifo_state_t st, next_st;
    logic push, pop;
    assign in_s.ready = (st.cnt != (AW+1)'(DEPTH)) && !flush;
    assign out_s.valid = (st.cnt != '0);
    assign out_s.data = st.mem[st.rp];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_s.data;
            next_st.wp = st.wp + AW'(1);
        end
        if (pop) begin
            next_st.rp = st.rp + AW'(1);
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            next_st.wp = '0;
            next_st.rp = '0;
            next_st.cnt = '0;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    a_fifo_no_overfill: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st.cnt <= (AW+1)'(DEPTH)) else $error("fifo count exceeds depth");
endmodule : spp_fifo
`default_nettype wire

// *** rtl/spp_port.sv ***
// Serial peripheral port: registers on a 16-bit peripheral bus, shifter and pins.
// Assumes synchronous inputs; external slave clock at most system clock / 8.
`default_nettype none
module spp_port
    import spp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    output logic irq,
    output logic irq_high_priority,
    input wire logic emu_suspend,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    input wire logic slave_strobe_pin_in,
    output logic slave_strobe_pin_out,
    output logic slave_strobe_pin_oe,
    input wire logic data_line_into_slave_in,
    output logic data_line_into_slave_out,
    output logic data_line_into_slave_oe,
    input wire logic data_line_out_of_slave_in,
    output logic data_line_out_of_slave_out,
    output logic data_line_out_of_slave_oe
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] ctl;
        logic ovr;
        logic cc;
        logic [6:0] brate;
        logic [7:0] rxbuf;
        logic [7:0] shreg;
        logic [7:0] pc1;
        logic [7:0] pc2;
        logic [7:0] pri;
        logic busy;
        logic [3:0] bits_left;
        logic [6:0] div_cnt;
        logic half;
        logic sclk;
        logic sclk_prev;
        logic rx_bit;
        logic out_bit;
        logic unread;
        logic push_rx;
    } spp_state_t;
    spp_state_t st, next_st;

    function automatic logic [3:0] char_len(input logic [7:0] cfg);
        return {1'b0, cfg[2:0]} + 4'h1;
    endfunction

    function automatic logic [6:0] half_period(input logic [6:0] br);
        return ((br < BRATE_MIN) ? BRATE_SLOW_DIV : br);
    endfunction

    // Odd periods split unevenly so that the full period is exactly rate plus one, or 4 for rates below 3
    function automatic logic [6:0] half_reload(input logic [6:0] br, input logic second);
        logic [7:0] per;
        logic [7:0] first;
        per = {1'b0, half_period(br)} + 8'h01;
        first = per >> 1;
        return second ? 7'(per - first - 8'h01) : 7'(first - 8'h01);
    endfunction

    logic master, pol, phase, swrst, strobe_gate, rd_buf, sample_in;
    logic [3:0] len;
    spp_fifo_if #(.WIDTH(FIFO_WIDTH)) rx_in ();
    spp_fifo_if #(.WIDTH(FIFO_WIDTH)) rx_out ();

    assign master = st.ctl[CTL_MASTER];
    assign pol = st.cfg[CFG_POL];
    assign phase = st.ctl[CTL_PHASE];
    assign swrst = st.cfg[CFG_SWRST];
    assign len = char_len(st.cfg);
    // Strobe gates only a slave with the strobe function chosen
    assign strobe_gate = !master && st.pc1[PC1_STB_FN] && slave_strobe_pin_in;
    assign rd_buf = bus_rd && bus_addr == ADDR_RXBUF;
    assign sample_in = master ? data_line_out_of_slave_in : data_line_into_slave_in;

    // Received characters also queue here; rx_out is always ready and its data is not used
    assign rx_in.valid = st.push_rx;
    assign rx_in.data = st.rxbuf;
    assign rx_out.ready = 1'b1;
    spp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(swrst),
        .in_s(rx_in),
        .out_s(rx_out)
    );

    always_comb begin
        logic lead, trail, tick, suspended, done;
        next_st = st;
        suspended = emu_suspend && !st.pri[PRI_SUSP];
        tick = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        done = 1'b0;
        next_st.sclk_prev = serial_clock_pin_in;
        if (master) begin
            if (st.busy && !suspended) begin
                if (st.div_cnt == 7'h00) begin
                    next_st.div_cnt = half_reload(st.brate, !st.half);
                    tick = 1'b1;
                end else begin
                    next_st.div_cnt = st.div_cnt - 7'h01;
                end
            end
            lead = tick && !st.half;
            trail = tick && st.half;
            if (tick) begin
                next_st.half = !st.half;
                next_st.sclk = !st.sclk;
            end
        end else if (!strobe_gate) begin
            // Edges of the external clock, relative to idle polarity
            lead = (serial_clock_pin_in ^ pol) && !(st.sclk_prev ^ pol);
            trail = !(serial_clock_pin_in ^ pol) && (st.sclk_prev ^ pol);
        end
        // Capture on one edge, shift out on the opposite; phase swaps the two edges
        if (st.busy || !master) begin
            if (phase ? trail : lead) begin
                next_st.rx_bit = sample_in;
            end
            if (phase ? lead : trail) begin
                next_st.shreg = {st.shreg[6:0], st.rx_bit};
                next_st.bits_left = st.bits_left - 4'h1;
                next_st.out_bit = st.shreg[6];
                if (st.bits_left == 4'h1) begin
                    done = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.bits_left = len;
                    next_st.rxbuf = {st.shreg[6:0], st.rx_bit};
                    next_st.cc = 1'b1;
                    next_st.unread = 1'b1;
                    if (st.unread) begin
                        next_st.ovr = 1'b1;
                    end
                    next_st.sclk = 1'b0;
                    next_st.half = 1'b0;
                end
            end
        end
        next_st.push_rx = done;
        // A completing character wins over a read in the same cycle
        if (rd_buf && !done) begin
            next_st.cc = 1'b0;
            next_st.unread = 1'b0;
        end
        if (bus_wr) begin
            unique case (bus_addr)
                ADDR_CONFIG: next_st.cfg = bus_wdata[7:0];
                ADDR_OPCTL: next_st.ctl = {3'h0, bus_wdata[4:0]};
                ADDR_STATUS: begin
                    if (bus_wdata[STS_OVR] && !(done && st.unread)) begin
                        next_st.ovr = 1'b0;
                    end
                end
                ADDR_BRATE: next_st.brate = bus_wdata[6:0];
                ADDR_SHIFT: begin
                    next_st.shreg = bus_wdata[7:0];
                    next_st.out_bit = bus_wdata[7];
                    next_st.bits_left = len;
                    next_st.busy = master;
                    next_st.div_cnt = half_reload(st.brate, 1'b0);
                    next_st.half = 1'b0;
                    next_st.sclk = 1'b0;
                end
                ADDR_PC1: next_st.pc1 = bus_wdata[7:0];
                ADDR_PC2: next_st.pc2 = bus_wdata[7:0];
                ADDR_PRI: next_st.pri = {1'b0, bus_wdata[6:5], 5'h00};
                default: ;
            endcase
        end
        if (!master && next_st.bits_left == 4'h0) begin
            next_st.bits_left = len;
        end
        if (swrst) begin
            next_st.ovr = 1'b0;
            next_st.cc = 1'b0;
            next_st.unread = 1'b0;
            next_st.busy = 1'b0;
            next_st.bits_left = len;
            next_st.sclk = 1'b0;
            next_st.half = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        bus_rdata = {8'h00, UNDEF_READ};
        unique case (bus_addr)
            ADDR_CONFIG: bus_rdata[7:0] = st.cfg;
            ADDR_OPCTL: bus_rdata[7:0] = st.ctl;
            ADDR_STATUS: bus_rdata[7:0] = {st.ovr, st.cc, 6'h00};
            ADDR_BRATE: bus_rdata[7:0] = {1'b0, st.brate};
            ADDR_EMU: bus_rdata[7:0] = st.rxbuf;
            ADDR_RXBUF: bus_rdata[7:0] = st.rxbuf;
            ADDR_SHIFT: bus_rdata[7:0] = st.shreg;
            ADDR_PC1: bus_rdata[7:0] = st.pc1;
            ADDR_PC2: bus_rdata[7:0] = st.pc2;
            ADDR_PRI: bus_rdata[7:0] = st.pri;
            default: ;
        endcase
    end

    assign irq = (st.cc && st.ctl[CTL_CC_IE]) || (st.ovr && st.ctl[CTL_OVR_IE]);
    assign irq_high_priority = st.pri[PRI_LEVEL];
    assign serial_clock_pin_out = st.sclk ^ pol;
    assign serial_clock_pin_oe = master;
    // Strobe as general-purpose output from pin_control_one bit 0
    assign slave_strobe_pin_out = st.pc1[0];
    assign slave_strobe_pin_oe = master || !st.pc1[PC1_STB_FN] ? st.pc1[1] : 1'b0;
    assign data_line_into_slave_out = st.out_bit;
    assign data_line_into_slave_oe = master && st.ctl[CTL_TALK];
    assign data_line_out_of_slave_out = st.out_bit;
    assign data_line_out_of_slave_oe = !master && st.ctl[CTL_TALK] && !strobe_gate;

    a_ovr_needs_unread: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(st.ovr) |-> $past(st.unread)) else $error("overrun without unread char");
    a_emu_keeps_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus_rd && bus_addr == ADDR_EMU && !rd_buf && st.cc && !swrst) |=> st.cc)
        else $error("emulation read cleared flag");
    a_rd_clears_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_buf && st.cc && !(st.busy && st.bits_left == 4'h1)) |=> !st.cc)
        else $error("buffer read kept flag");
    a_strobe_tristate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        strobe_gate |-> !data_line_out_of_slave_oe) else $error("slave drives when deselected");
    a_master_clock_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
        serial_clock_pin_oe == master) else $error("clock direction wrong");
    a_swrst_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        swrst |=> !st.cc && !st.ovr && !st.busy) else $error("soft reset left state");
    a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.cc && st.ctl[CTL_CC_IE]) |-> irq) else $error("irq missing");
    a_start_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus_wr && bus_addr == ADDR_SHIFT && master && !swrst) |=> st.busy)
        else $error("write did not start transfer");
endmodule : spp_port
`default_nettype wire

// *** verif/spp_partner.sv ***
// Behavioural far-side slave for the serial port: one 8-bit shift register.
// Assumes clock polarity 0, phase 0 and a select line that is active low.
`default_nettype none
module spp_partner (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] shreg = 8'h00;
    logic cap = 1'b0;
    logic got = 1'b0;
    // Capture on the rising edge; the master changes its data on the falling one
    always @(posedge sclk) begin
        if (!sel_n) begin
            cap <= mosi;
            got <= 1'b1;
        end
    end
    // Shift only while the master clocks, one bit in per bit out
    always @(negedge sclk) begin
        if (!sel_n && got) begin
            shreg <= {shreg[6:0], cap};
            got <= 1'b0;
        end
    end
    // Deselected output shows the inverse, never a held bit
    assign miso = sel_n ? ~shreg[7] : shreg[7];
    task automatic load(input logic [7:0] v);
        shreg = v;
        got = 1'b0;
    endtask
    // Last captured bit is still pending until the next falling edge
    function automatic logic [7:0] rx_view();
        return got ? {shreg[6:0], cap} : shreg;
    endfunction
endmodule // spp_partner
`default_nettype wire

// *** verif/tb_serial_peripheral_port.sv ***
// Self-checking bench for spp_port: bus tasks, far-side slave, queue of notes.
// Assumes the package register map; strobe line idles high when undriven.
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
    $display("BAD %s expected %h seen %h", nm, e, s); end end
module tb_serial_peripheral_port
    import spp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {string nm; logic [1:0] sel; logic [15:0] ev;} spp_note_t;
    logic clk_sys = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, probe = 1'b0, tb_ste = 1'b1;
    logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata, cnt = 16'h0001, meas = 16'h0000, seen, t;
    logic irq, irq_hp, sclk_o, sclk_oe, ste_o, ste_oe, simo_o, simo_oe, somi_o, somi_oe;
    logic sclk_w, ste_w, simo_w, somi_w, p_miso, sclk_q = 1'b0;
    logic [7:0] tx, sv;
    int err_count = 0, check_count = 0;
    spp_note_t notes[$];
    spp_note_t cur;
    localparam logic [15:0] RSV[6] = '{16'h7043, 16'h7045, 16'h7048, 16'h704A, 16'h704B, 16'h704C};
    localparam logic [15:0] ALL[10] = '{ADDR_CONFIG, ADDR_OPCTL, ADDR_STATUS, ADDR_BRATE, ADDR_EMU,
        ADDR_RXBUF, ADDR_SHIFT, ADDR_PC1, ADDR_PC2, ADDR_PRI};
    localparam logic [15:0] RWA[5] = '{ADDR_CONFIG, ADDR_OPCTL, ADDR_BRATE, ADDR_PC1, ADDR_PRI};
    localparam logic [7:0] RWM[5] = '{8'h47, 8'h1F, 8'h7F, 8'h23, 8'h60};
    localparam logic [7:0] RATE[4] = '{8'h01, 8'h02, 8'h05, 8'h7F};
    localparam logic [15:0] PER[4] = '{16'h0004, 16'h0004, 16'h0006, 16'h0080};
    always #5 clk_sys = ~clk_sys;
    // Undriven lines never keep a stale level
    assign sclk_w = sclk_oe ? sclk_o : 1'b0;
    assign ste_w = ste_oe ? ste_o : tb_ste;
    assign simo_w = simo_oe ? simo_o : ~simo_o;
    assign somi_w = somi_oe ? somi_o : p_miso;
    spp_port u_spp_port (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .irq_high_priority(irq_hp), .emu_suspend(1'b0),
        .serial_clock_pin_in(sclk_w), .serial_clock_pin_out(sclk_o), .serial_clock_pin_oe(sclk_oe),
        .slave_strobe_pin_in(ste_w), .slave_strobe_pin_out(ste_o), .slave_strobe_pin_oe(ste_oe),
        .data_line_into_slave_in(simo_w), .data_line_into_slave_out(simo_o), .data_line_into_slave_oe(simo_oe),
        .data_line_out_of_slave_in(somi_w), .data_line_out_of_slave_out(somi_o),
        .data_line_out_of_slave_oe(somi_oe)
    );
    spp_partner u_spp_partner (.sclk(sclk_w), .sel_n(ste_w), .mosi(simo_w), .miso(p_miso));
    // Period of the serial clock in system cycles, rising edge to rising edge
    always @(posedge clk_sys) begin
        if (sclk_w && !sclk_q) begin
            meas <= cnt;
            cnt <= 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
        end
        sclk_q <= sclk_w;
        if ((bus_rd || probe) && notes.size() > 0) begin
            cur = notes.pop_front();
            case (cur.sel)
                2'h0: seen = bus_rdata;
                2'h1: seen = {9'h000, sclk_oe, ste_oe, ste_o, simo_oe, somi_oe, irq, irq_hp};
                2'h2: seen = meas;
                default: seen = {8'h00, u_spp_partner.rx_view()};
            endcase
            `CHK(cur.nm, cur.ev, seen)
        end
    end
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Idle cycle after each access so strobes never toggle twice in one step
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge clk_sys);
        #1 bus_wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic note(input logic [1:0] sel, input logic [15:0] a, input logic [15:0] e, input string nm);
        notes.push_back('{nm, sel, e});
        bus_addr = a;
        bus_rd = (sel == 2'h0);
        probe = (sel != 2'h0);
        @(posedge clk_sys);
        #1 bus_rd = 1'b0;
        probe = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic xfer(input logic [7:0] s);
        int n;
        u_spp_partner.load(s);
        tx = 8'($urandom);
        wr(ADDR_SHIFT, {8'($urandom), tx});
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 3000) begin
            err_count++;
            $display("BAD irq wait expected 1 seen 0");
        end
    endtask
    initial begin
        void'($urandom(32'h6F28));
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        foreach (RSV[i]) wr(RSV[i], 16'hFFFF);
        foreach (RSV[i]) note(2'h0, RSV[i], 16'h0000, "reserved read");
        foreach (ALL[i]) note(2'h0, ALL[i], 16'h0000, "reset value");
        foreach (RWA[i]) begin
            t = 16'($urandom);
            t[7:0] = t[7:0] & RWM[i];
            wr(RWA[i], t);
            note(2'h0, RWA[i], {8'h00, t[7:0]}, "read back");
        end
        wr(ADDR_BRATE, 16'h0003);
        wr(ADDR_PC1, 16'h0022);
        wr(ADDR_PRI, 16'h0040);
        wr(ADDR_OPCTL, 16'h0007);
        note(2'h1, ADDR_PC1, 16'h0069, "master pins");
        for (int len = 1; len <= 8; len++) begin
            wr(ADDR_CONFIG, 16'(len - 1));
            sv = 8'($urandom);
            xfer(sv);
            t = {sv, tx} << len;
            note(2'h3, ADDR_PC1, {8'h00, t[15:8]}, "slave received");
            t = {tx, sv} << len;
            note(2'h1, ADDR_PC1, 16'h006B, "irq on char");
            note(2'h0, ADDR_EMU, {8'h00, t[15:8]}, "emulation buffer");
            note(2'h0, ADDR_STATUS, 16'h0040, "flag after emu read");
            note(2'h0, ADDR_RXBUF, {8'h00, t[15:8]}, "receive buffer");
            note(2'h0, ADDR_STATUS, 16'h0000, "flag after read");
        end
        xfer(8'($urandom));
        wr(ADDR_OPCTL, 16'h0016);
        note(2'h1, ADDR_PC1, 16'h0069, "irq masked");
        sv = 8'($urandom);
        xfer(sv);
        note(2'h1, ADDR_PC1, 16'h006B, "overrun irq");
        note(2'h0, ADDR_STATUS, 16'h00C0, "overrun");
        note(2'h0, ADDR_RXBUF, {8'h00, sv}, "newest char");
        note(2'h0, ADDR_STATUS, 16'h0080, "overrun stays");
        wr(ADDR_STATUS, 16'h0080);
        note(2'h0, ADDR_STATUS, 16'h0000, "overrun cleared");
        wr(ADDR_OPCTL, 16'h0007);
        xfer(8'($urandom));
        wr(ADDR_CONFIG, 16'h0087);
        note(2'h0, ADDR_STATUS, 16'h0000, "flag in soft reset");
        wr(ADDR_CONFIG, 16'h0007);
        foreach (RATE[i]) begin
            wr(ADDR_BRATE, {8'h00, RATE[i]});
            sv = 8'($urandom);
            xfer(sv);
            note(2'h2, ADDR_PC1, PER[i], "clock period");
            note(2'h0, ADDR_RXBUF, {8'h00, sv}, "rate char");
        end
        wr(ADDR_OPCTL, 16'h0002);
        wr(ADDR_PC1, 16'h0020);
        note(2'h1, ADDR_PC1, 16'h0001, "strobe inactive");
        tb_ste = 1'b0;
        note(2'h1, ADDR_PC1, 16'h0005, "strobe active");
        finish_test();
    end
    // Whole sequence needs well under 30000 cycles
    initial begin
        #400000;
        err_count++;
        $display("BAD watchdog expected done seen hang");
        finish_test();
    end
endmodule // tb_serial_peripheral_port
`default_nettype wire
